/* src/gac_core.sv */
// Auxiliary command decoder for listener and controller local messages
`timescale 1ns/1ps
// Overview of operation
// - Code 11011 pulses listen, enters continuous mode
// - Continuous mode: ready on not-ready start unless end
// - End with byte enters holdoff, no ready
// - Continuous mode never sets data received flag
// - Listen command or listener idle leaves continuous
// - Code 11100 pulses local unlisten once
// - Code 11101 sets and holds parallel poll request
// - Poll or idle controller clears poll request
// - IFC commands request system control, drive IFC
// - REN commands request system control, drive REN
// - Code 10100 clears system control request
// - Code 10011 pulses listen once
// - Standby set while active, cleared leaving active
module gac_core
  import gac_pkg::*;
(
  input  wire logic              clk,         // 50 MHz system clock
  input  wire logic              nrst,        // Synchronous reset, active low
  input  wire logic [ADDR_W-1:0] addr,        // Register address
  input  wire logic [DATA_W-1:0] wdata,       // Write data
  input  wire logic              wr,          // Write strobe
  input  wire logic              rd,          // Read strobe
  output logic      [DATA_W-1:0] rdata,       // Read data, cycle after rd
  input  wire logic              cacs,        // Controller active state
  input  wire logic              cpps,        // Controller parallel poll state
  input  wire logic              cids,        // Controller idle state
  input  wire logic              lids,        // Listener idle state
  input  wire logic              anrs_start,  // Acceptor not-ready state begins
  input  wire logic              byte_rcvd,   // Data byte accepted, one cycle
  input  wire logic              end_rcvd,    // End of block seen with the byte
  output logic                   ltn,         // Local listen pulse
  output logic                   lun,         // Local unlisten pulse
  output logic                   rdy,         // Local ready pulse
  output logic                   rfd_holdoff, // Ready-for-data holdoff level
  output logic                   rpp,         // Request parallel poll level
  output logic                   gts,         // Go to standby level
  output logic                   rsc,         // Request system control level
  output logic                   ifc_out,     // Interface clear line drive
  output logic                   ren_out,     // Remote enable line drive
  output logic                   data_received_flag, // Sticky data received
  output logic                   irq          // Level interrupt
);

  // ==========================================================================
  // Reset image of the state word
  localparam gac_state_t RST = '{
    cont: 1'b0, hold: 1'b0, rpp: 1'b0, gts_req: 1'b0, gts: 1'b0,
    rsc: 1'b0, ifc: 1'b0, ren: 1'b0, ltn: 1'b0, lun: 1'b0, rdy: 1'b0,
    cacs_q: 1'b0, status: STATUS_RST, mask: MASK_RST, irq: 1'b0,
    rdata: '0};

  gac_state_t st;
  gac_state_t next_st;

  // Command strobe: upper bits zero means an auxiliary command, others are
  // hidden register loads handled elsewhere and ignored here
  function automatic logic is_cmd(input logic [ADDR_W-1:0] a,
                                  input logic              w,
                                  input logic [DATA_W-1:0] d,
                                  input logic [4:0]        code,
                                  input logic [4:0]        care);
    is_cmd = w && (a == ADDR_AUX) && (d[DATA_W-1:SEL_LSB] == '0) &&
             ((d[CMD_LSB +: CMD_W] & care) == (code & care));
  endfunction

  logic       c_ltn;
  logic       c_ltn_cont;
  logic       c_lun;
  logic       c_rpp;
  logic       c_gts;
  logic       c_dsc;
  logic       c_ifc;
  logic       c_ren;
  logic       cmd_val;
  logic [EV_W-1:0] ev;

  // Same-cycle decode of every command this block owns
  always_comb begin
    c_ltn      = is_cmd(addr, wr, wdata, CMD_LTN, 5'h1F);
    c_ltn_cont = is_cmd(addr, wr, wdata, CMD_LTN_CONT, 5'h1F);
    c_lun      = is_cmd(addr, wr, wdata, CMD_LUN, 5'h1F);
    c_rpp      = is_cmd(addr, wr, wdata, CMD_RPP, 5'h1F);
    c_gts      = is_cmd(addr, wr, wdata, CMD_GTS, 5'h1F);
    c_dsc      = is_cmd(addr, wr, wdata, CMD_DSC, 5'h1F);
    c_ifc      = is_cmd(addr, wr, wdata, CMD_IFC, CMD_VAL_MASK);
    c_ren      = is_cmd(addr, wr, wdata, CMD_REN, CMD_VAL_MASK);
    cmd_val    = wdata[VAL_BIT];
  end

  // ==========================================================================
  // Next-state logic
  always_comb begin
    next_st = st;

    // Pulses live for exactly one cycle
    next_st.ltn = c_ltn | c_ltn_cont;
    next_st.lun = c_lun;
    next_st.cacs_q = cacs;

    // Continuous mode: the plain listen command or listener idle ends it,
    // and the continuous listen command wins over listener idle in one cycle
    if (c_ltn_cont) begin
      next_st.cont = 1'b1;
    end else if (c_ltn || lids) begin
      next_st.cont = 1'b0;
    end

    // Holdoff only exists inside continuous mode
    if (!next_st.cont) begin
      next_st.hold = 1'b0;
    end else if (st.cont && byte_rcvd && end_rcvd) begin
      next_st.hold = 1'b1;
    end

    // Automatic ready, suppressed by holdoff or an end on this very byte
    next_st.rdy = st.cont && anrs_start && !st.hold &&
                  !(byte_rcvd && end_rcvd);

    // Poll request holds until the controller polls or goes idle; the
    // state clear wins since the poll it asked for has begun
    if (cpps || cids) begin
      next_st.rpp = 1'b0;
    end else if (c_rpp) begin
      next_st.rpp = 1'b1;
    end

    // Standby request waits for the active state, dropped on leaving it
    if (c_gts) begin
      next_st.gts_req = 1'b1;
    end else if (st.cacs_q && !cacs) begin
      next_st.gts_req = 1'b0;
    end
    next_st.gts = next_st.gts_req && cacs;

    // System control and the two line drives
    if (c_ifc) begin
      next_st.rsc = 1'b1;
      next_st.ifc = cmd_val;
    end else if (c_ren) begin
      next_st.rsc = 1'b1;
      next_st.ren = cmd_val;
    end else if (c_dsc) begin
      next_st.rsc = 1'b0;
    end

    // Events; a set in the same cycle as a write-one clear survives
    ev = '0;
    ev[ST_DATA] = byte_rcvd && !st.cont;
    ev[ST_HOLD] = st.cont && byte_rcvd && end_rcvd && !st.hold;
    if (wr && addr == ADDR_STATUS) begin
      next_st.status = st.status & ~wdata[EV_W-1:0];
    end
    next_st.status = next_st.status | ev;
    if (wr && addr == ADDR_MASK) begin
      next_st.mask = wdata[EV_W-1:0];
    end
    next_st.irq = |(next_st.status & next_st.mask);

    // Read data stand only in the cycle after the strobe
    next_st.rdata = '0;
    if (rd) begin
      unique case (addr)
        ADDR_AUX: begin
          next_st.rdata[RB_CONT]   = st.cont;
          next_st.rdata[RB_HOLD]   = st.hold;
          next_st.rdata[RB_RPP]    = st.rpp;
          next_st.rdata[RB_GTS]    = st.gts;
          next_st.rdata[RB_RSC]    = st.rsc;
          next_st.rdata[RB_IFC]    = st.ifc;
          next_st.rdata[RB_REN]    = st.ren;
          next_st.rdata[RB_GTSREQ] = st.gts_req;
        end
        ADDR_STATUS: next_st.rdata[EV_W-1:0] = st.status;
        ADDR_MASK:   next_st.rdata[EV_W-1:0] = st.mask;
        default:     next_st.rdata = '0;
      endcase
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st <= RST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state word
  assign rdata              = st.rdata;
  assign ltn                = st.ltn;
  assign lun                = st.lun;
  assign rdy                = st.rdy;
  assign rfd_holdoff        = st.hold;
  assign rpp                = st.rpp;
  assign gts                = st.gts;
  assign rsc                = st.rsc;
  assign ifc_out            = st.ifc;
  assign ren_out            = st.ren;
  assign data_received_flag = st.status[ST_DATA];
  assign irq                = st.irq;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_cont_cmd;
    c_ltn_cont;
  endsequence

  sequence s_cont_entered;
    ltn && st.cont;
  endsequence

  a_cont_entry_listen:
    assert property (s_cont_cmd |=> s_cont_entered)
    else $error("continuous listen command did not pulse listen and enter mode");

  a_ready_auto_issue:
    assert property (st.cont && anrs_start && !st.hold && !(byte_rcvd && end_rcvd)
                     |=> rdy)
    else $error("ready not issued at acceptor not-ready start");

  a_holdoff_no_ready:
    assert property (st.cont && byte_rcvd && end_rcvd ##1 st.cont
                     |-> rfd_holdoff && !rdy)
    else $error("end of block did not hold off ready");

  a_cont_no_data:
    assert property (st.cont && byte_rcvd && !$past(data_received_flag)
                     && !data_received_flag |=> !data_received_flag)
    else $error("data flag set in continuous mode");

  a_cont_exit_ctl:
    assert property ((c_ltn || lids) && !c_ltn_cont |=> !st.cont)
    else $error("continuous mode not left on listen or listener idle");

  a_lun_one_pulse:
    assert property (c_lun ##1 !c_lun |-> lun ##1 !lun)
    else $error("unlisten not a single pulse");

  // The poll state answers within a few cycles, so only two quiet cycles
  // are asked for; a longer window would never be reached in practice
  sequence s_rpp_set;
    c_rpp && !cpps && !cids;
  endsequence

  sequence s_rpp_quiet;
    (!cpps && !cids) [*2];
  endsequence

  a_rpp_held:
    assert property (s_rpp_set ##1 s_rpp_quiet |-> rpp [*2])
    else $error("poll request not held");

  a_rpp_cleared:
    assert property (cpps || cids |=> !rpp)
    else $error("poll request not cleared by poll or idle state");

  a_ifc_value_drive:
    assert property (c_ifc |=> rsc && ifc_out == $past(wdata[VAL_BIT]))
    else $error("interface clear command drove wrong value");

  a_ren_value_drive:
    assert property (c_ren |=> rsc && ren_out == $past(wdata[VAL_BIT]))
    else $error("remote enable command drove wrong value");

  a_rsc_disable:
    assert property (c_dsc |=> !rsc)
    else $error("system control request not cleared");

  a_listen_pulse:
    assert property (c_ltn ##1 !c_ltn && !c_ltn_cont |-> ltn ##1 !ltn)
    else $error("listen not a single pulse");

  a_gts_tracks_cacs:
    assert property (gts |-> $past(cacs))
    else $error("standby asserted outside controller active");

  a_gts_drop:
    assert property ($fell(cacs) && !c_gts |=> !gts && !st.gts_req)
    else $error("standby not cleared on leaving active state");

  a_irq_level:
    assert property (##1 irq == |(st.status & st.mask))
    else $error("interrupt does not follow unmasked status");

  // Quiet and set cycles: outputs that only commands or bus events may move
  a_rdy_only_cont:
    assert property (!st.cont |=> !rdy)
    else $error("ready issued outside continuous mode");

  a_hold_blocks_rdy:
    assert property (st.hold |=> !rdy)
    else $error("ready issued during holdoff");

  a_hold_needs_cont:
    assert property (rfd_holdoff |-> st.cont)
    else $error("holdoff outside continuous mode");

  a_data_flag_set:
    assert property (byte_rcvd && !st.cont |=> data_received_flag)
    else $error("data flag not set outside continuous mode");

  a_lun_only_cmd:
    assert property (!c_lun |=> !lun)
    else $error("unlisten pulse without command");

  a_ltn_only_cmd:
    assert property (!c_ltn && !c_ltn_cont |=> !ltn)
    else $error("listen pulse without command");

  a_rpp_set_next:
    assert property (s_rpp_set |=> rpp)
    else $error("poll request not set");

  a_gts_while_active:
    assert property ((c_gts || st.gts_req) && cacs |=> gts)
    else $error("standby not issued in controller active state");

  a_ifc_hold:
    assert property (!c_ifc |=> $stable(ifc_out))
    else $error("interface clear line moved without command");

  a_ren_hold:
    assert property (!c_ren |=> $stable(ren_out))
    else $error("remote enable line moved without command");

  a_rsc_hold:
    assert property (!c_ifc && !c_ren && !c_dsc |=> $stable(rsc))
    else $error("system control request moved without command");

  a_rdata_idle:
    assert property (!rd |=> rdata == '0)
    else $error("read data present without a read");

endmodule // gac_core

/* src/gac_pkg.sv */
// Package of constants and types for the auxiliary command listener/controller block
package gac_pkg;

  // ==========================================================================
  // Register bus layout
  localparam int          ADDR_W       = 3;
  localparam int          DATA_W       = 8;
  localparam logic [2:0]  ADDR_AUX     = 3'h0;  // Command write, state read
  localparam logic [2:0]  ADDR_STATUS  = 3'h1;  // Sticky events, write one to clear
  localparam logic [2:0]  ADDR_MASK    = 3'h2;  // Interrupt mask

  // Command field layout inside the command write
  localparam int          CMD_LSB      = 0;
  localparam int          CMD_W        = 5;
  localparam int          SEL_LSB      = 5;     // Upper bits select a hidden register
  localparam int          VAL_BIT      = 3;     // aux_command_value_bit

  // ==========================================================================
  // Command codes
  localparam logic [4:0]  CMD_GTS      = 5'h10;
  localparam logic [4:0]  CMD_LTN      = 5'h13;
  localparam logic [4:0]  CMD_DSC      = 5'h14;
  localparam logic [4:0]  CMD_LTN_CONT = 5'h1B;
  localparam logic [4:0]  CMD_LUN      = 5'h1C;
  localparam logic [4:0]  CMD_RPP      = 5'h1D;
  localparam logic [4:0]  CMD_IFC      = 5'h16; // Bit 3 carries the line value
  localparam logic [4:0]  CMD_REN      = 5'h17; // Bit 3 carries the line value
  localparam logic [4:0]  CMD_VAL_MASK = 5'h17; // Compare with the value bit ignored

  // ==========================================================================
  // Status and state read-back bit positions
  localparam int          ST_DATA      = 0;     // Byte received outside continuous mode
  localparam int          ST_HOLD      = 1;     // Holdoff entered on end of block
  localparam int          EV_W         = 2;
  localparam logic [1:0]  STATUS_RST   = 2'h0;
  localparam logic [1:0]  MASK_RST     = 2'h0;

  localparam int          RB_CONT      = 0;
  localparam int          RB_HOLD      = 1;
  localparam int          RB_RPP       = 2;
  localparam int          RB_GTS       = 3;
  localparam int          RB_RSC       = 4;
  localparam int          RB_IFC       = 5;
  localparam int          RB_REN       = 6;
  localparam int          RB_GTSREQ    = 7;

  // ==========================================================================
  // Whole state of the block, registered as one word
  typedef struct packed {
    logic              cont;      // Continuous listening mode
    logic              hold;      // Ready-for-data holdoff
    logic              rpp;
    logic              gts_req;   // Go-to-standby requested, waits for active
    logic              gts;
    logic              rsc;
    logic              ifc;
    logic              ren;
    logic              ltn;
    logic              lun;
    logic              rdy;
    logic              cacs_q;    // Controller active, one cycle old
    logic [EV_W-1:0]   status;
    logic [EV_W-1:0]   mask;
    logic              irq;
    logic [DATA_W-1:0] rdata;
  } gac_state_t;

endpackage

/* test/gac_far_model.sv */
// Behavioural model of the bus interface functions facing the command decoder
`timescale 1ns/1ps
module gac_far_model (
  input  wire logic clk,        // System clock
  input  wire logic nrst,       // Synchronous reset, active low
  input  wire logic rpp,        // Request parallel poll from the core
  input  wire logic ctl_active, // Controller wants the active state
  input  wire logic lis_idle,   // Listener idle request
  input  wire logic send,       // Deliver one data byte
  input  wire logic send_end,   // Byte carries end of block
  output logic      cacs,       // Controller active state
  output logic      cpps,       // Controller parallel poll state
  output logic      cids,       // Controller idle state
  output logic      lids,       // Listener idle state
  output logic      anrs_start, // Acceptor not-ready begins
  output logic      byte_rcvd,  // Byte accepted pulse
  output logic      end_rcvd    // End flag, valid with the byte only
);
  logic poll_q;
  // ==========================================================================
  // Controller states; poll state follows a request two cycles later
  assign cacs = ctl_active & ~cpps;
  assign cids = ~ctl_active;
  assign lids = lis_idle;
  // Acceptor goes not-ready right after each byte; end flag toggles outside bytes
  always_ff @(posedge clk) begin
    if (!nrst) begin
      poll_q <= 1'b0;
      cpps <= 1'b0;
      byte_rcvd <= 1'b0;
      anrs_start <= 1'b0;
      end_rcvd <= 1'b0;
    end else begin
      poll_q <= rpp & ctl_active;
      cpps <= poll_q;
      byte_rcvd <= send;
      anrs_start <= byte_rcvd;
      end_rcvd <= send ? send_end : ~end_rcvd;  // Never a stale end flag
    end
  end
endmodule  // gac_far_model

/* test/tb.sv */
// Self-checking testbench of the auxiliary command decoder
`timescale 1ns/1ps
module tb;
  import gac_pkg::*;
  logic              clk, nrst, wr, rd, send, send_end, ctl_active, lis_idle;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic              cacs, cpps, cids, lids, anrs_start, byte_rcvd, end_rcvd;
  logic              ltn, lun, rdy, rfd_holdoff, rpp, gts, rsc, ifc_out, ren_out;
  logic              data_received_flag, irq;
  int                err_count, checks_done, rdy_cnt;

  gac_core i_gac_core (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .cacs(cacs), .cpps(cpps), .cids(cids), .lids(lids),
    .anrs_start(anrs_start), .byte_rcvd(byte_rcvd), .end_rcvd(end_rcvd), .ltn(ltn),
    .lun(lun), .rdy(rdy), .rfd_holdoff(rfd_holdoff), .rpp(rpp), .gts(gts), .rsc(rsc),
    .ifc_out(ifc_out), .ren_out(ren_out), .data_received_flag(data_received_flag),
    .irq(irq));
  gac_far_model i_gac_far_model (.clk(clk), .nrst(nrst), .rpp(rpp),
    .ctl_active(ctl_active), .lis_idle(lis_idle), .send(send), .send_end(send_end),
    .cacs(cacs), .cpps(cpps), .cids(cids), .lids(lids), .anrs_start(anrs_start),
    .byte_rcvd(byte_rcvd), .end_rcvd(end_rcvd));

  // ==========================================================================
  // Clock, ready pulse counter and hang guard
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) if (rdy === 1'b1) rdy_cnt++;
  initial begin
    #1000000;  // 50000 cycles, far beyond a clean run
    err_count++;
    print_verdict();
  end

  // ==========================================================================
  // Bus tasks: strobe for one cycle, results looked at once settled
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic wcmd(input logic [4:0] c);
    wr_reg(ADDR_AUX, {3'h0, c});
  endtask
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] exp, input string n);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(n, exp, rdata);
  endtask
  // Byte from the far side, then time for the acceptor to go not-ready
  task automatic put_byte(input logic e);
    @(posedge clk);
    send <= 1'b1;
    send_end <= e;
    @(posedge clk);
    send <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    nrst = 1'b0; wr = 1'b0; rd = 1'b0; addr = '0; wdata = '0; send = 1'b0;
    send_end = 1'b0; ctl_active = 1'b1; lis_idle = 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rd_chk(ADDR_STATUS, 8'h00, "status");
    rd_chk(ADDR_MASK, 8'h00, "mask");
    rd_chk(3'h5, 8'h00, "unmapped");
    $display("test reset done");
    wcmd(CMD_LTN_CONT);
    chk("ltn", 8'h01, ltn);
    @(posedge clk); #1 chk("ltn", 8'h00, ltn);
    rd_chk(ADDR_AUX, 8'h01, "aux");
    put_byte(1'b0);
    chk("rdy count", 8'h01, rdy_cnt[7:0]);
    rd_chk(ADDR_STATUS, 8'h00, "status");
    wr_reg(ADDR_MASK, 8'h02);
    put_byte(1'b1);
    chk("holdoff", 8'h01, rfd_holdoff);
    chk("rdy count", 8'h01, rdy_cnt[7:0]);
    chk("irq", 8'h01, irq);
    rd_chk(ADDR_STATUS, 8'h02, "status");
    wr_reg(ADDR_STATUS, 8'h02);
    @(posedge clk); #1 chk("irq", 8'h00, irq);
    $display("test continuous mode done");
    wcmd(CMD_LTN);
    chk("ltn", 8'h01, ltn);
    @(posedge clk); #1 chk("ltn", 8'h00, ltn);
    rd_chk(ADDR_AUX, 8'h00, "aux");
    put_byte(1'b0);
    chk("data flag", 8'h01, data_received_flag);
    chk("rdy count", 8'h01, rdy_cnt[7:0]);
    wr_reg(ADDR_STATUS, 8'h01);
    wcmd(CMD_LTN_CONT);
    @(posedge clk) lis_idle <= 1'b1;
    @(posedge clk) lis_idle <= 1'b0;
    rd_chk(ADDR_AUX, 8'h00, "aux");
    $display("test listen exit done");
    wcmd(CMD_LUN);
    chk("lun", 8'h01, lun);
    @(posedge clk); #1 chk("lun", 8'h00, lun);
    wcmd(CMD_RPP);
    chk("rpp", 8'h01, rpp);
    @(posedge clk); #1 chk("rpp", 8'h01, rpp);
    repeat (4) @(posedge clk);
    #1 chk("rpp", 8'h00, rpp);
    @(posedge clk) ctl_active <= 1'b0;
    wcmd(CMD_RPP);
    chk("rpp", 8'h00, rpp);
    $display("test poll done");
    wcmd(CMD_GTS);
    chk("gts", 8'h00, gts);
    @(posedge clk) ctl_active <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("gts", 8'h01, gts);
    @(posedge clk) ctl_active <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("gts", 8'h00, gts);
    @(posedge clk) ctl_active <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("gts", 8'h00, gts);
    $display("test standby done");
    wcmd(CMD_IFC | 5'h08);
    chk("rsc", 8'h01, rsc);
    chk("ifc", 8'h01, ifc_out);
    repeat (5000) @(posedge clk);
    wcmd(CMD_IFC);
    chk("ifc", 8'h00, ifc_out);
    chk("rsc", 8'h01, rsc);
    wcmd(CMD_REN | 5'h08);
    chk("ren", 8'h01, ren_out);
    chk("rsc", 8'h01, rsc);
    wcmd(CMD_REN);
    chk("ren", 8'h00, ren_out);
    wcmd(CMD_DSC);
    chk("rsc", 8'h00, rsc);
    wr_reg(ADDR_AUX, 8'h3B);
    chk("ltn", 8'h00, ltn);
    $display("test system control done");
    print_verdict();
  end
endmodule  // tb
